// ===== core/phyatr_pkg.sv
// Package for the analog tuning register bank: word indices, field layout, reset values.
// Assumes an APB slave with 32-bit data, one 16-bit register per aligned word.
package phyatr_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_FINE_GAIN_CD  = 10'h0a1;
  localparam logic [9:0] IDX_SWING_AB      = 10'h0a2;
  localparam logic [9:0] IDX_SWING_CD      = 10'h0a3;
  localparam logic [9:0] IDX_RX_LOWPASS    = 10'h0b3;
  localparam logic [9:0] IDX_RX_EQ_ENABLE  = 10'h0c0;
  localparam logic [9:0] IDX_CLKOUT_CTRL   = 10'h0c6;
  localparam logic [9:0] IDX_SYNC_BUFFER   = 10'h0e9;
  localparam logic [9:0] IDX_LOOPBACK      = 10'h0fe;
  localparam logic [9:0] IDX_SIGPROC       = 10'h100;
  localparam logic [9:0] IDX_FFE           = 10'h12c;

  // Field positions
  localparam int GAIN_D_LSB     = 8;
  localparam int GAIN_C_LSB     = 0;
  localparam int GAIN_W         = 4;
  localparam int SWING_HI_EN    = 13;
  localparam int SWING_HI_LSB   = 8;
  localparam int SWING_LO_EN    = 5;
  localparam int SWING_LO_LSB   = 0;
  localparam int SWING_W        = 5;
  localparam int CLKOUT_SEL_BIT = 4;
  localparam int FFE_W          = 10;

  // Values after reset, fixed reserved bits and gain step
  localparam logic [4:0]  RST_SWING_B      = 5'h08;
  localparam logic [4:0]  RST_SWING_ACD    = 5'h10;
  localparam logic [15:0] RST_SYNC_BUFFER  = 16'h9f22;
  localparam logic [15:0] RST_LOOPBACK     = 16'h0001;
  localparam logic [15:0] RST_SIGPROC      = 16'h051c;
  localparam logic [5:0]  FFE_RSVD_VALUE   = 6'h03;
  localparam logic [3:0]  GAIN_NEUTRAL     = 4'h8;
  localparam logic [5:0]  GAIN_STEP_PCT    = 6'h02;

endpackage

// ===== core/phyatr_regs.sv
// APB register bank holding analog and DSP tuning words of the transceiver.
// Assumes an APB4 master, zero-wait answers, and a soft reset pulse from the control block.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Fine transmit gain for channel D sits in bits 11:8 and channel C in bits 3:0, coded as channel A.
// - Gain codes step by 2 percent from minus 16 at code 0 through none at 8 to plus 14 at 15, trimmed at power-up.
// - The A/B swing register holds B override enable at bit 13 with value 12:8, A enable at bit 5 with value 4:0, enables reset low.
// - The C/D swing register holds D enable at bit 13 with value 12:8, C enable at bit 5 with value 4:0, values reset to 10000.
// - Clock-output select bit 4 high routes the internal transmit clock to the clock output, low keeps normal output.
// - Clock-output control bits 15:5 and 3:0 ignore writes and read as zero.
// - A changed loopback word takes effect only on the soft reset pulse from control bit 14.
// - The signal processor setup word resets to 0x051C and is fully writable.
module phyatr_regs #(
  parameter int          ADDR_W        = 12,
  parameter logic [15:0] RST_RX_LOWPASS = 16'h0000,
  parameter logic [15:0] RST_RX_EQ      = 16'h0000,
  parameter logic [9:0]  RST_FFE_FIELD  = 10'h000
) (
  input  wire logic              pclk,                          // APB clock, 10 MHz
  input  wire logic              presetn,                       // Async reset, active low
  input  wire logic              psel,                          // APB select
  input  wire logic              penable,                       // APB access phase
  input  wire logic              pwrite,                        // APB write
  input  wire logic [ADDR_W-1:0] paddr,                         // APB byte address
  input  wire logic [31:0]       pwdata,                        // APB write data
  input  wire logic [3:0]        pstrb,                         // APB byte strobes
  output logic [31:0]            prdata,                        // APB read data
  output logic                   pready,                        // APB ready
  output logic                   pslverr,                       // APB error on unmapped access
  input  wire logic [3:0]        trim_gain_c,                   // Factory trim, channel C
  input  wire logic [3:0]        trim_gain_d,                   // Factory trim, channel D
  input  wire logic              soft_reset_pulse,              // One-cycle soft reset
  input  wire logic              internal_transmit_clock,       // Transmit clock for test
  input  wire logic              normal_clock_source,           // Normal clock-output source
  output logic                   clock_output,                  // Clock output pin
  output logic [3:0]             fine_gain_chan_c,              // Gain code channel C
  output logic [3:0]             fine_gain_chan_d,              // Gain code channel D
  output logic [5:0]             gain_change_pct_c,             // Signed gain change, channel C
  output logic [5:0]             gain_change_pct_d,             // Signed gain change, channel D
  output logic                   swing_override_en_a,           // Swing override enable A
  output logic                   swing_override_en_b,           // Swing override enable B
  output logic                   swing_override_en_c,           // Swing override enable C
  output logic                   swing_override_en_d,           // Swing override enable D
  output logic [4:0]             swing_value_a,                 // Swing value A
  output logic [4:0]             swing_value_b,                 // Swing value B
  output logic [4:0]             swing_value_c,                 // Swing value C
  output logic [4:0]             swing_value_d,                 // Swing value D
  output logic [15:0]            rx_lowpass_word,               // Receive low-pass setup
  output logic [15:0]            rx_equalizer_enable_word,      // Receive equalizer enables
  output logic [15:0]            sync_buffer_word,              // Sync buffer setup
  output logic [15:0]            loopback_word,                 // Loopback word in force
  output logic [15:0]            signal_processor_word,         // Signal processor setup
  output logic [9:0]             feedforward_equalizer_field    // Feed-forward equalizer
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [9:0]  word_idx;
  logic        aligned;
  logic        hit;
  logic        wr_en;
  logic        setup_rd;

  assign word_idx = paddr[11:2];
  assign aligned  = (paddr[1:0] == 2'h0);

  always_comb begin
    hit = 1'b0;
    if (aligned) begin
      case (word_idx)
        phyatr_pkg::IDX_FINE_GAIN_CD,
        phyatr_pkg::IDX_SWING_AB,
        phyatr_pkg::IDX_SWING_CD,
        phyatr_pkg::IDX_RX_LOWPASS,
        phyatr_pkg::IDX_RX_EQ_ENABLE,
        phyatr_pkg::IDX_CLKOUT_CTRL,
        phyatr_pkg::IDX_SYNC_BUFFER,
        phyatr_pkg::IDX_LOOPBACK,
        phyatr_pkg::IDX_SIGPROC,
        phyatr_pkg::IDX_FFE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign wr_en    = psel & penable & pwrite & hit;
  assign setup_rd = psel & ~penable & ~pwrite;

  // Byte-lane merge of the low half word; upper lanes hold nothing
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st);
    logic [15:0] r;
    r = old_v;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // two percent per code step around the neutral code
  function automatic logic [5:0] gain_pct(input logic [3:0] code);
    logic [5:0] d;
    d = {2'b00, code} - {2'b00, phyatr_pkg::GAIN_NEUTRAL};
    return 6'(d * phyatr_pkg::GAIN_STEP_PCT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic        trim_loaded_r, trim_loaded_nxt;
  logic [3:0]  gain_c_r, gain_c_nxt;
  logic [3:0]  gain_d_r, gain_d_nxt;
  logic [15:0] swing_ab_r, swing_ab_nxt;
  logic [15:0] swing_cd_r, swing_cd_nxt;
  logic [15:0] lowpass_r, lowpass_nxt;
  logic [15:0] rx_eq_r, rx_eq_nxt;
  logic        clk_sel_r, clk_sel_nxt;
  logic [15:0] sync_buf_r, sync_buf_nxt;
  logic [15:0] loop_stage_r, loop_stage_nxt;
  logic [15:0] loop_live_r, loop_live_nxt;
  logic [15:0] sigproc_r, sigproc_nxt;
  logic [9:0]  ffe_r, ffe_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [15:0] wv;
  logic [15:0] rd_word;

  always_comb begin
    trim_loaded_nxt = 1'b1;
    gain_c_nxt      = gain_c_r;
    gain_d_nxt      = gain_d_r;
    swing_ab_nxt    = swing_ab_r;
    swing_cd_nxt    = swing_cd_r;
    lowpass_nxt     = lowpass_r;
    rx_eq_nxt       = rx_eq_r;
    clk_sel_nxt     = clk_sel_r;
    sync_buf_nxt    = sync_buf_r;
    loop_stage_nxt  = loop_stage_r;
    loop_live_nxt   = loop_live_r;
    sigproc_nxt     = sigproc_r;
    ffe_nxt         = ffe_r;
    wv              = 16'h0000;
    // trim straps are caught on the first edge after reset release
    if (!trim_loaded_r) begin
      gain_c_nxt = trim_gain_c;
      gain_d_nxt = trim_gain_d;
    end
    // fields change on a completed write, besides the trim load and the soft reset
    if (wr_en) begin
      case (word_idx)
        phyatr_pkg::IDX_FINE_GAIN_CD: begin
          // channel D high nibble, channel C low nibble
          wv = merge16({4'h0, gain_d_r, 4'h0, gain_c_r}, pwdata, pstrb);
          gain_d_nxt = wv[phyatr_pkg::GAIN_D_LSB +: phyatr_pkg::GAIN_W];
          gain_c_nxt = wv[phyatr_pkg::GAIN_C_LSB +: phyatr_pkg::GAIN_W];
        end
        phyatr_pkg::IDX_SWING_AB: begin
          // enables at 13 and 5, values at 12:8 and 4:0
          wv = merge16(swing_ab_r, pwdata, pstrb);
          swing_ab_nxt = wv & 16'h3f3f;
        end
        phyatr_pkg::IDX_SWING_CD: begin
          // same layout for channels D and C
          wv = merge16(swing_cd_r, pwdata, pstrb);
          swing_cd_nxt = wv & 16'h3f3f;
        end
        phyatr_pkg::IDX_RX_LOWPASS: begin
          lowpass_nxt = merge16(lowpass_r, pwdata, pstrb);
        end
        phyatr_pkg::IDX_RX_EQ_ENABLE: begin
          rx_eq_nxt = merge16(rx_eq_r, pwdata, pstrb);
        end
        phyatr_pkg::IDX_CLKOUT_CTRL: begin
          // only the select bit is stored
          if (pstrb[0]) begin
            clk_sel_nxt = pwdata[phyatr_pkg::CLKOUT_SEL_BIT];
          end
        end
        phyatr_pkg::IDX_SYNC_BUFFER: begin
          sync_buf_nxt = merge16(sync_buf_r, pwdata, pstrb);
        end
        phyatr_pkg::IDX_LOOPBACK: begin
          // the word is staged, any value accepted
          loop_stage_nxt = merge16(loop_stage_r, pwdata, pstrb);
        end
        phyatr_pkg::IDX_SIGPROC: begin
          sigproc_nxt = merge16(sigproc_r, pwdata, pstrb);
        end
        phyatr_pkg::IDX_FFE: begin
          // low ten bits only; a 0x0E81 write lands fully
          wv = merge16({phyatr_pkg::FFE_RSVD_VALUE, ffe_r}, pwdata, pstrb);
          ffe_nxt = wv[phyatr_pkg::FFE_W-1:0];
        end
        default: begin
          wv = 16'h0000;
        end
      endcase
    end
    // staged loopback word goes live only on soft reset
    if (soft_reset_pulse) begin
      loop_live_nxt = loop_stage_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the setup phase so prdata is a flop

  always_comb begin
    rd_word = 16'h0000;
    case (word_idx)
      phyatr_pkg::IDX_FINE_GAIN_CD: rd_word = {4'h0, gain_d_r, 4'h0, gain_c_r};
      phyatr_pkg::IDX_SWING_AB:     rd_word = swing_ab_r;
      phyatr_pkg::IDX_SWING_CD:     rd_word = swing_cd_r;
      phyatr_pkg::IDX_RX_LOWPASS:   rd_word = lowpass_r;
      phyatr_pkg::IDX_RX_EQ_ENABLE: rd_word = rx_eq_r;
      // all other bits of clock-output control read zero
      phyatr_pkg::IDX_CLKOUT_CTRL:  rd_word = {11'h000, clk_sel_r, 4'h0};
      phyatr_pkg::IDX_SYNC_BUFFER:  rd_word = sync_buf_r;
      phyatr_pkg::IDX_LOOPBACK:     rd_word = loop_stage_r;
      phyatr_pkg::IDX_SIGPROC:      rd_word = sigproc_r;
      // reserved upper bits read their fixed value
      phyatr_pkg::IDX_FFE:          rd_word = {phyatr_pkg::FFE_RSVD_VALUE, ffe_r};
      default:                      rd_word = 16'h0000;
    endcase
    prdata_nxt = prdata_r;
    if (setup_rd) begin
      prdata_nxt = (hit) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_loaded_r <= 1'b0;
      gain_c_r      <= phyatr_pkg::GAIN_NEUTRAL;
      gain_d_r      <= phyatr_pkg::GAIN_NEUTRAL;
      swing_ab_r    <= {3'h0, phyatr_pkg::RST_SWING_B, 3'h0, phyatr_pkg::RST_SWING_ACD};
      swing_cd_r    <= {3'h0, phyatr_pkg::RST_SWING_ACD, 3'h0, phyatr_pkg::RST_SWING_ACD};
      lowpass_r     <= RST_RX_LOWPASS;
      rx_eq_r       <= RST_RX_EQ;
      clk_sel_r     <= 1'b0;
      sync_buf_r    <= phyatr_pkg::RST_SYNC_BUFFER;
      loop_stage_r  <= phyatr_pkg::RST_LOOPBACK;
      loop_live_r   <= phyatr_pkg::RST_LOOPBACK;
      sigproc_r     <= phyatr_pkg::RST_SIGPROC;
      ffe_r         <= RST_FFE_FIELD;
      prdata_r      <= 32'h0000_0000;
    end else begin
      trim_loaded_r <= trim_loaded_nxt;
      gain_c_r      <= gain_c_nxt;
      gain_d_r      <= gain_d_nxt;
      swing_ab_r    <= swing_ab_nxt;
      swing_cd_r    <= swing_cd_nxt;
      lowpass_r     <= lowpass_nxt;
      rx_eq_r       <= rx_eq_nxt;
      clk_sel_r     <= clk_sel_nxt;
      sync_buf_r    <= sync_buf_nxt;
      loop_stage_r  <= loop_stage_nxt;
      loop_live_r   <= loop_live_nxt;
      sigproc_r     <= sigproc_nxt;
      ffe_r         <= ffe_nxt;
      prdata_r      <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, straight from the registers

  assign prdata = prdata_r;

  // clock routing is a plain mux; glitches on a select change are accepted in test mode
  assign clock_output = clk_sel_r ? internal_transmit_clock : normal_clock_source;

  assign fine_gain_chan_c            = gain_c_r;
  assign fine_gain_chan_d            = gain_d_r;
  assign gain_change_pct_c           = gain_pct(gain_c_r);
  assign gain_change_pct_d           = gain_pct(gain_d_r);
  assign swing_override_en_a         = swing_ab_r[phyatr_pkg::SWING_LO_EN];
  assign swing_override_en_b         = swing_ab_r[phyatr_pkg::SWING_HI_EN];
  assign swing_override_en_c         = swing_cd_r[phyatr_pkg::SWING_LO_EN];
  assign swing_override_en_d         = swing_cd_r[phyatr_pkg::SWING_HI_EN];
  assign swing_value_a               = swing_ab_r[phyatr_pkg::SWING_LO_LSB +: phyatr_pkg::SWING_W];
  assign swing_value_b               = swing_ab_r[phyatr_pkg::SWING_HI_LSB +: phyatr_pkg::SWING_W];
  assign swing_value_c               = swing_cd_r[phyatr_pkg::SWING_LO_LSB +: phyatr_pkg::SWING_W];
  assign swing_value_d               = swing_cd_r[phyatr_pkg::SWING_HI_LSB +: phyatr_pkg::SWING_W];
  assign rx_lowpass_word             = lowpass_r;
  assign rx_equalizer_enable_word    = rx_eq_r;
  assign sync_buffer_word            = sync_buf_r;
  assign loopback_word               = loop_live_r;
  assign signal_processor_word       = sigproc_r;
  assign feedforward_equalizer_field = ffe_r;

endmodule

`default_nettype wire

// ===== bench/phyatr_chk.sv
// Checker for the tuning register bank: bus refusals, field updates, clock mux.
// Assumes zero-wait APB and that field checks only need full low-lane writes.
`timescale 1ns/1ps
`default_nettype none
module phyatr_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,                        // Clock
  input wire logic              presetn,                     // Reset, active low
  input wire logic              psel,                        // Select
  input wire logic              penable,                     // Access phase
  input wire logic              pwrite,                      // Write
  input wire logic [ADDR_W-1:0] paddr,                       // Byte address
  input wire logic [31:0]       pwdata,                      // Write data
  input wire logic [3:0]        pstrb,                       // Strobes
  input wire logic [31:0]       prdata,                      // Read data
  input wire logic              pslverr,                     // Error
  input wire logic              soft_reset_pulse,            // Soft reset
  input wire logic              internal_transmit_clock,     // Test clock
  input wire logic              normal_clock_source,         // Normal clock
  input wire logic              clock_output,                // Clock pin
  input wire logic [3:0]        fine_gain_chan_c,            // Gain C
  input wire logic [3:0]        fine_gain_chan_d,            // Gain D
  input wire logic [5:0]        gain_change_pct_c,           // Gain change C
  input wire logic              swing_override_en_a,         // Enable A
  input wire logic              swing_override_en_b,         // Enable B
  input wire logic [4:0]        swing_value_a,               // Swing A
  input wire logic [4:0]        swing_value_b,               // Swing B
  input wire logic [15:0]       loopback_word,               // Live loopback
  input wire logic [15:0]       signal_processor_word,       // Processor setup
  input wire logic [9:0]        feedforward_equalizer_field  // Equalizer field
);
  logic [9:0] idx;
  logic       wr;
  logic       rd;
  assign idx = 10'(paddr >> 2);
  // Partial-lane writes are left to the bench, so these only fire on full low lanes
  assign wr = psel && penable && pwrite && paddr[1:0] == 2'b00 && pstrb[1:0] == 2'b11;
  assign rd = psel && penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  chk_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  chk_read_upper: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_clkout_rsvd: assert property (rd && idx == phyatr_pkg::IDX_CLKOUT_CTRL |->
    (prdata & 32'hffffffef) == 32'h0)
    else $error("clock-output reserved bits not zero");
  chk_clkout_mux: assert property (wr && idx == phyatr_pkg::IDX_CLKOUT_CTRL |=>
    clock_output == ($past(pwdata[4]) ? internal_transmit_clock : normal_clock_source))
    else $error("clock output source wrong");
  chk_gain_write: assert property (wr && idx == phyatr_pkg::IDX_FINE_GAIN_CD |=>
    fine_gain_chan_d == $past(pwdata[11:8]) && fine_gain_chan_c == $past(pwdata[3:0]))
    else $error("gain fields not updated");
  chk_gain_pct: assert property (gain_change_pct_c == {1'b0, fine_gain_chan_c, 1'b0} - 6'h10)
    else $error("gain change mapping wrong");
  chk_swing_write: assert property (wr && idx == phyatr_pkg::IDX_SWING_AB |=>
    swing_override_en_b == $past(pwdata[13]) && swing_value_b == $past(pwdata[12:8]) &&
    swing_override_en_a == $past(pwdata[5]) && swing_value_a == $past(pwdata[4:0]))
    else $error("swing fields not updated");
  chk_loop_hold: assert property (!soft_reset_pulse |=> $stable(loopback_word))
    else $error("loopback changed without soft reset");
  chk_sigproc_write: assert property (wr && idx == phyatr_pkg::IDX_SIGPROC |=>
    signal_processor_word == $past(pwdata[15:0]))
    else $error("processor setup not updated");
  chk_ffe_write: assert property (wr && idx == phyatr_pkg::IDX_FFE |=>
    feedforward_equalizer_field == $past(pwdata[9:0]))
    else $error("equalizer field not updated");
  cov_refused: cover property (rd && pslverr);
  cov_loop_apply: cover property (wr && idx == phyatr_pkg::IDX_LOOPBACK ##[1:20] soft_reset_pulse);
  cov_clk_switch: cover property ($changed(clock_output));
endmodule
`default_nettype wire

// ===== bench/phy_analog_tuning_regs_test.sv
// Self-checking bench for the tuning register bank, driven as an APB master.
// Assumes the bank answers with no wait states and reloads trim after each reset.
`timescale 1ns/1ps
`default_nettype none
module phy_analog_tuning_regs_test;
  localparam logic [15:0] LP_RST = 16'h00a5;
  localparam logic [15:0] EQ_RST = 16'h005a;
  // Fifteen-bit loopback pattern, top bit left clear
  localparam logic [15:0] LOOP_VAL = 16'h7390;
  localparam logic [9:0] REG_IDX [10] = '{phyatr_pkg::IDX_FINE_GAIN_CD, phyatr_pkg::IDX_SWING_AB,
    phyatr_pkg::IDX_SWING_CD, phyatr_pkg::IDX_RX_LOWPASS, phyatr_pkg::IDX_RX_EQ_ENABLE,
    phyatr_pkg::IDX_CLKOUT_CTRL, phyatr_pkg::IDX_SYNC_BUFFER, phyatr_pkg::IDX_LOOPBACK,
    phyatr_pkg::IDX_SIGPROC, phyatr_pkg::IDX_FFE};
  localparam logic [15:0] RST_EXP [10] = '{16'h0c03, 16'h0810, 16'h1010, LP_RST, EQ_RST,
    16'h0000, 16'h9f22, 16'h0001, 16'h051c, 16'h0c00};
  localparam logic [15:0] ONE_EXP [10] = '{16'h0f0f, 16'h3f3f, 16'h3f3f, 16'hffff, 16'hffff,
    16'h0010, 16'hffff, 16'hffff, 16'hffff, 16'h0fff};
  logic        pclk, presetn, psel, penable, pwrite, soft_reset_pulse, pready, pslverr, er_v;
  logic        internal_transmit_clock, normal_clock_source, clock_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  pstrb, trim_gain_c, trim_gain_d, fine_gain_chan_c, fine_gain_chan_d;
  logic [5:0]  gain_change_pct_c, gain_change_pct_d;
  logic        swing_override_en_a, swing_override_en_b, swing_override_en_c, swing_override_en_d;
  logic [4:0]  swing_value_a, swing_value_b, swing_value_c, swing_value_d;
  logic [15:0] rx_lowpass_word, rx_equalizer_enable_word, sync_buffer_word, loopback_word;
  logic [15:0] signal_processor_word;
  logic [9:0]  feedforward_equalizer_field;
  int          n_mismatch = 0;
  int          check_count = 0;

  phyatr_regs #(.RST_RX_LOWPASS(LP_RST), .RST_RX_EQ(EQ_RST)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trim_gain_c(trim_gain_c), .trim_gain_d(trim_gain_d),
    .soft_reset_pulse(soft_reset_pulse), .internal_transmit_clock(internal_transmit_clock),
    .normal_clock_source(normal_clock_source), .clock_output(clock_output),
    .fine_gain_chan_c(fine_gain_chan_c), .fine_gain_chan_d(fine_gain_chan_d),
    .gain_change_pct_c(gain_change_pct_c), .gain_change_pct_d(gain_change_pct_d),
    .swing_override_en_a(swing_override_en_a), .swing_override_en_b(swing_override_en_b),
    .swing_override_en_c(swing_override_en_c), .swing_override_en_d(swing_override_en_d),
    .swing_value_a(swing_value_a), .swing_value_b(swing_value_b),
    .swing_value_c(swing_value_c), .swing_value_d(swing_value_d),
    .rx_lowpass_word(rx_lowpass_word), .rx_equalizer_enable_word(rx_equalizer_enable_word),
    .sync_buffer_word(sync_buffer_word), .loopback_word(loopback_word),
    .signal_processor_word(signal_processor_word),
    .feedforward_equalizer_field(feedforward_equalizer_field));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Entered just after a rising edge; an idle cycle follows so no signal is set twice at once
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb_xfer(1'b1, {i, 2'b00}, d, 4'hf, rd_v, er_v);
  endtask

  task automatic rc(input string nm, input logic [9:0] i, input logic [31:0] e);
    apb_xfer(1'b0, {i, 2'b00}, 32'h0, 4'h0, rd_v, er_v);
    check(nm, rd_v, e);
  endtask

  // Release, then two edges so trim has landed before the first setup
  task automatic reset_dut();
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    soft_reset_pulse = 1'b0;
    trim_gain_c = 4'h3;
    trim_gain_d = 4'hc;
    internal_transmit_clock = 1'b1;
    normal_clock_source = 1'b0;
    reset_dut();
    check("gain cd", 32'({fine_gain_chan_d, fine_gain_chan_c}), 32'hc3);
    check("pct cd", 32'({gain_change_pct_d, gain_change_pct_c}), 32'h236);
    check("swing bd", 32'({swing_value_b, swing_value_d}), 32'h110);
    for (int i = 0; i < 10; i++) rc("reset", REG_IDX[i], 32'(RST_EXP[i]));
    for (int i = 0; i < 10; i++) begin
      wr(REG_IDX[i], 32'hffffffff);
      rc("ones", REG_IDX[i], 32'(ONE_EXP[i]));
    end
    check("enables", 32'({swing_override_en_a, swing_override_en_b, swing_override_en_c,
      swing_override_en_d}), 32'hf);
    check("swings", 32'(swing_value_a & swing_value_b & swing_value_c & swing_value_d), 32'h1f);
    check("live loop", 32'(loopback_word), 32'h1);
    check("sync word", 32'(sync_buffer_word), 32'hffff);
    check("test clock", 32'(clock_output), 32'h1);
    internal_transmit_clock <= 1'b0;
    @(posedge pclk);
    check("test clock lo", 32'(clock_output), 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(REG_IDX[i], 32'h0);
      rc("zeros", REG_IDX[i], (i == 9) ? 32'h0c00 : 32'h0);
    end
    check("normal clock lo", 32'(clock_output), 32'h0);
    normal_clock_source <= 1'b1;
    @(posedge pclk);
    check("normal clock hi", 32'(clock_output), 32'h1);
    wr(phyatr_pkg::IDX_RX_LOWPASS, 32'h000c);
    wr(phyatr_pkg::IDX_SIGPROC, 32'h1027);
    wr(phyatr_pkg::IDX_FFE, 32'h0e81);
    check("lowpass", 32'(rx_lowpass_word), 32'h000c);
    check("eq", 32'(rx_equalizer_enable_word), 32'h0);
    check("sigproc", 32'(signal_processor_word), 32'h1027);
    check("ffe", 32'(feedforward_equalizer_field), 32'h281);
    rc("ffe word", phyatr_pkg::IDX_FFE, 32'h0e81);
    wr(phyatr_pkg::IDX_LOOPBACK, 32'(LOOP_VAL));
    check("loop held", 32'(loopback_word), 32'h1);
    rc("loop staged", phyatr_pkg::IDX_LOOPBACK, 32'(LOOP_VAL));
    soft_reset_pulse <= 1'b1;
    @(posedge pclk);
    soft_reset_pulse <= 1'b0;
    @(posedge pclk);
    check("loop applied", 32'(loopback_word), 32'(LOOP_VAL));
    apb_xfer(1'b1, {phyatr_pkg::IDX_FINE_GAIN_CD, 2'b00}, 32'h050a, 4'h1, rd_v, er_v);
    check("low lane", 32'({fine_gain_chan_d, fine_gain_chan_c}), 32'h0a);
    apb_xfer(1'b0, 12'h290, 32'h0, 4'h0, rd_v, er_v);
    check("unmapped", {rd_v[30:0], er_v}, 32'h1);
    apb_xfer(1'b1, 12'h285, 32'h0f0f, 4'hf, rd_v, er_v);
    check("misaligned", 32'({er_v, fine_gain_chan_d, fine_gain_chan_c}), 32'h10a);
    presetn <= 1'b0;
    reset_dut();
    check("loop reset", 32'(loopback_word), 32'h1);
    rc("sigproc reset", phyatr_pkg::IDX_SIGPROC, 32'h051c);
    results();
  end
endmodule

bind phyatr_regs phyatr_chk #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .soft_reset_pulse(soft_reset_pulse), .internal_transmit_clock(internal_transmit_clock),
  .normal_clock_source(normal_clock_source), .clock_output(clock_output),
  .fine_gain_chan_c(fine_gain_chan_c), .fine_gain_chan_d(fine_gain_chan_d),
  .gain_change_pct_c(gain_change_pct_c), .swing_override_en_a(swing_override_en_a),
  .swing_override_en_b(swing_override_en_b), .swing_value_a(swing_value_a),
  .swing_value_b(swing_value_b), .loopback_word(loopback_word),
  .signal_processor_word(signal_processor_word),
  .feedforward_equalizer_field(feedforward_equalizer_field));
`default_nettype wire
